// [inc/ddpp_regs.svh]
`ifndef DDPP_REGS_SVH
`define DDPP_REGS_SVH
`define DDPP_CLK_PERIOD_NS 40
`define DDPP_CYC_MIN(ns) (((ns) + `DDPP_CLK_PERIOD_NS - 1) / `DDPP_CLK_PERIOD_NS)
`define DDPP_T_RCS_NS 150
`define DDPP_T_CSD_NS 150
`define DDPP_T_WCS_NS 40
`define DDPP_T_SETUP_NS 10
`define DDPP_T_HOLD_NS 10
`define DDPP_T_LS_NS 30
`define DDPP_T_LH_NS 100
`define DDPP_T_LX_NS 100
`define DDPP_T_LWD_NS 100
`define DDPP_T_RST_NS 10
`define DDPP_CYC_RCS ((`DDPP_CYC_MIN(`DDPP_T_RCS_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_RCS_NS))
`define DDPP_CYC_WCS ((`DDPP_CYC_MIN(`DDPP_T_WCS_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_WCS_NS))
`define DDPP_CYC_SETUP ((`DDPP_CYC_MIN(`DDPP_T_SETUP_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_SETUP_NS))
`define DDPP_CYC_HOLD ((`DDPP_CYC_MIN(`DDPP_T_HOLD_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_HOLD_NS))
`define DDPP_CYC_LX ((`DDPP_CYC_MIN(`DDPP_T_LX_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_LX_NS))
`define DDPP_CYC_LWD ((`DDPP_CYC_MIN(`DDPP_T_LWD_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_LWD_NS))
`define DDPP_CYC_RST ((`DDPP_CYC_MIN(`DDPP_T_RST_NS) < 1) ? 1 : `DDPP_CYC_MIN(`DDPP_T_RST_NS))
`define DDPP_CODE_MID 16'h8000
`define DDPP_CODE_ZERO 16'h0000
`endif

// [inc/ddpp_pkg.sv]
`default_nettype none
package ddpp_pkg;
  typedef enum logic [1:0] {DDPP_OP_WRITE, DDPP_OP_READ, DDPP_OP_LOAD, DDPP_OP_RESET} ddpp_op_t;
  typedef enum {DDPP_IDLE, DDPP_SETUP, DDPP_STROBE, DDPP_HOLD, DDPP_LOW, DDPP_DONE} ddpp_state_t;
endpackage
`default_nettype wire

// [src/ddpp_timer.sv]
`default_nettype none
module ddpp_timer
  import ddpp_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic expired
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
    begin
      cnt_next = count;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - WIDTH'(1);
    end
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end
  // Expires when count reaches one, so a count of n gives n cycles
  // No load term here: the caller loads on expiry, which would close a loop
  assign expired = (cnt_reg <= WIDTH'(1));
endmodule
`default_nettype wire

// [src/ddpp_host.sv]
// Operation
// - One load strobe edge updates both channels; the strobe may be shared by several devices.
// - Chip select low with read/write low writes the bus word to A or B by channel select.
// - Chip select low with read/write high makes the device drive A or B onto the bus.
// - With chip select high a load strobe rise updates both outputs and holds the inputs.
`include "ddpp_regs.svh"
`default_nettype none
module ddpp_host
  import ddpp_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_OP,
  input wire logic REQ_CHAN,
  input wire logic [DATA_W-1:0] REQ_DATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_DATA,
  output logic CS_N,
  output logic RW,
  output logic CHANNEL_SELECT,
  output logic OUTPUT_LOAD_STROBE,
  output logic RESET_STROBE,
  output logic [DATA_W-1:0] DB_O,
  output logic DB_OE,
  input wire logic [DATA_W-1:0] DB_I
);
  ddpp_state_t state_reg, state_next;
  ddpp_op_t op_reg, op_next;
  logic cs_n_reg, cs_n_next;
  logic rw_reg, rw_next;
  logic sel_reg, sel_next;
  logic load_reg, load_next;
  logic rst_reg, rst_next;
  logic oe_reg, oe_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic [DATA_W-1:0] rsp_reg, rsp_next;
  logic rsp_v_reg, rsp_v_next;
  logic ready_reg, ready_next;
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_done;

  // Strobe width for each operation; reads must cover the data valid delay
  function automatic logic [7:0] pulse_cycles(input ddpp_op_t op);
    case (op)
      DDPP_OP_WRITE: pulse_cycles = 8'(`DDPP_CYC_WCS);
      DDPP_OP_READ: pulse_cycles = 8'(`DDPP_CYC_RCS);
      DDPP_OP_LOAD: pulse_cycles = 8'(`DDPP_CYC_LX);
      default: pulse_cycles = 8'(`DDPP_CYC_RST);
    endcase
  endfunction

  ddpp_timer #(.WIDTH(8)) u_timer (
    .clk(CLK_SYS),
    .srst(SRST),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_done)
  );

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    cs_n_next = cs_n_reg;
    rw_next = rw_reg;
    sel_next = sel_reg;
    load_next = load_reg;
    rst_next = rst_reg;
    oe_next = oe_reg;
    dout_next = dout_reg;
    rsp_next = rsp_reg;
    rsp_v_next = 1'b0;
    tmr_load = 1'b0;
    tmr_count = 8'(`DDPP_CYC_SETUP);
    case (state_reg)
      DDPP_IDLE:
      begin
        if (REQ_VALID)
        begin
          op_next = ddpp_op_t'(REQ_OP);
          sel_next = REQ_CHAN;
          rw_next = (ddpp_op_t'(REQ_OP) == DDPP_OP_READ);
          dout_next = REQ_DATA;
          // Host drives the bus only for writes, leaving it free during reads
          oe_next = (ddpp_op_t'(REQ_OP) == DDPP_OP_WRITE);
          tmr_load = 1'b1;
          state_next = DDPP_SETUP;
        end
      end
      DDPP_SETUP:
      begin
        if (tmr_done)
        begin
          case (op_reg)
            DDPP_OP_WRITE, DDPP_OP_READ: cs_n_next = 1'b0;
            DDPP_OP_LOAD: load_next = 1'b1;
            default: rst_next = 1'b1;
          endcase
          tmr_load = 1'b1;
          tmr_count = pulse_cycles(op_reg);
          state_next = DDPP_STROBE;
        end
      end
      DDPP_STROBE:
      begin
        if (tmr_done)
        begin
          if (op_reg == DDPP_OP_READ)
          begin
            rsp_next = DB_I;
            rsp_v_next = 1'b1;
          end
          // Single rising edge per access; chip select high holds the registers
          cs_n_next = 1'b1;
          tmr_load = 1'b1;
          tmr_count = 8'(`DDPP_CYC_HOLD);
          state_next = DDPP_HOLD;
        end
      end
      DDPP_HOLD:
      begin
        if (tmr_done)
        begin
          load_next = 1'b0;
          rst_next = 1'b0;
          oe_next = 1'b0;
          tmr_load = 1'b1;
          tmr_count = 8'(`DDPP_CYC_LWD);
          state_next = DDPP_LOW;
        end
      end
      DDPP_LOW:
      begin
        // Recovery keeps strobe low time and bus release margin before the next access
        if (tmr_done)
        begin
          state_next = DDPP_DONE;
        end
      end
      DDPP_DONE:
      begin
        state_next = DDPP_IDLE;
      end
      default:
      begin
        state_next = DDPP_IDLE;
      end
    endcase
    // Ready registered so the port comes straight from a flip-flop
    ready_next = (state_next == DDPP_IDLE);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      state_reg <= DDPP_IDLE;
      op_reg <= DDPP_OP_WRITE;
      cs_n_reg <= 1'b1;
      rw_reg <= 1'b1;
      sel_reg <= 1'b0;
      load_reg <= 1'b0;
      rst_reg <= 1'b0;
      oe_reg <= 1'b0;
      dout_reg <= '0;
      rsp_reg <= '0;
      rsp_v_reg <= 1'b0;
      ready_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      cs_n_reg <= cs_n_next;
      rw_reg <= rw_next;
      sel_reg <= sel_next;
      load_reg <= load_next;
      rst_reg <= rst_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      rsp_reg <= rsp_next;
      rsp_v_reg <= rsp_v_next;
      ready_reg <= ready_next;
    end
  end

  assign CS_N = cs_n_reg;
  assign RW = rw_reg;
  assign CHANNEL_SELECT = sel_reg;
  assign OUTPUT_LOAD_STROBE = load_reg;
  assign RESET_STROBE = rst_reg;
  assign DB_O = dout_reg;
  assign DB_OE = oe_reg;
  assign RSP_DATA = rsp_reg;
  assign RSP_VALID = rsp_v_reg;
  assign REQ_READY = ready_reg;

  chk_load_cs_high: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(load_reg) |-> cs_n_reg)
    else $error("load strobe rose with chip select low");
  chk_one_edge: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(cs_n_reg) |=> cs_n_reg [*5])
    else $error("chip select edge malformed");
  chk_write_no_load: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !cs_n_reg |-> !load_reg && !rst_reg)
    else $error("load or reset strobe during access");
  chk_sel_stable: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !cs_n_reg && !$fell(cs_n_reg) |-> $stable(sel_reg) && $stable(rw_reg))
    else $error("channel or direction changed during access");
  chk_read_no_drive: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (!cs_n_reg && rw_reg) |-> !oe_reg)
    else $error("host drove bus during read");
  chk_write_drive: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (!cs_n_reg && !rw_reg) |-> oe_reg && $stable(dout_reg))
    else $error("write data not driven");
  chk_read_width: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $fell(cs_n_reg) && rw_reg |-> !cs_n_reg [*4])
    else $error("read strobe too short");
  chk_load_width: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(load_reg) |-> load_reg [*3])
    else $error("load strobe too short");
  chk_reset_alone: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(rst_reg) |-> cs_n_reg && !load_reg)
    else $error("reset overlapped other strobes");
  chk_idle_hold: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (state_reg == DDPP_IDLE) |-> cs_n_reg && !load_reg && !rst_reg && !oe_reg)
    else $error("strobes active while idle");
  chk_read_resp: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(cs_n_reg) && rw_reg |-> rsp_v_reg)
    else $error("read response missing");
endmodule
`default_nettype wire

// [dv/ddpp_dev_model.sv]
`default_nettype none
module ddpp_dev_model
#(
  parameter logic [15:0] RST_CODE = 16'h8000
)
(
  input wire logic cs_n,
  input wire logic rw,
  input wire logic chan,
  input wire logic load,
  input wire logic rst,
  input wire logic [15:0] host_d,
  input wire logic host_oe,
  output logic [15:0] bus,
  output logic [15:0] dac_a,
  output logic [15:0] dac_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] in_a = RST_CODE;
  logic [15:0] in_b = RST_CODE;
  logic [15:0] last = 16'h0000;
  logic rd_on;
  initial dac_a = RST_CODE;
  initial dac_b = RST_CODE;
  assign rd_on = !cs_n && rw;
  // No keeper: a released bus shows the inverse of its last value
  assign bus = host_oe ? host_d : rd_on ? (chan ? in_b : in_a) : ~last;
  always @(bus)
  begin
    if (host_oe || rd_on)
      last = bus;
  end
  always @(posedge cs_n)
  begin
    if (!rw && chan)
      in_b = bus;
    else if (!rw)
      in_a = bus;
  end
  always @(posedge load)
  begin
    if (cs_n)
    begin
      dac_a = in_a;
      dac_b = in_b;
    end
  end
  always @(posedge rst)
  begin
    in_a = RST_CODE;
    in_b = RST_CODE;
    dac_a = RST_CODE;
    dac_b = RST_CODE;
  end
endmodule
`default_nettype wire

// [dv/test_ddpp_host.sv]
`include "ddpp_regs.svh"
`default_nettype none
module test_ddpp_host
  import ddpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic req_chan = 1'b0;
  logic [15:0] req_data = 16'h0000;
  logic req_ready, rsp_valid, cs_n, rw, chan, load, rst, db_oe;
  logic [15:0] rsp_data, db_o, bus, dac_a, dac_b, rd;
  int n_fail = 0;
  int checked = 0;
  always #20 clk = ~clk;
  ddpp_host ddpp_host_i (.CLK_SYS(clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_OP(req_op),
    .REQ_CHAN(req_chan), .REQ_DATA(req_data), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .CS_N(cs_n), .RW(rw), .CHANNEL_SELECT(chan),
    .OUTPUT_LOAD_STROBE(load), .RESET_STROBE(rst), .DB_O(db_o), .DB_OE(db_oe), .DB_I(bus));
  ddpp_dev_model ddpp_dev_model_i (.cs_n(cs_n), .rw(rw), .chan(chan), .load(load), .rst(rst),
    .host_d(db_o), .host_oe(db_oe), .bus(bus), .dac_a(dac_a), .dac_b(dac_b));
  task final_report();
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One request, then wait for ready under a bound; a read word lands in rd
  task op(input ddpp_op_t o, input logic c, input logic [15:0] d);
    int i;
    rd = 16'hxxxx;
    req_valid = 1'b1;
    req_op = o;
    req_chan = c;
    req_data = d;
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 40 && req_ready !== 1'b1; i++)
    begin
      @(negedge clk);
      if (rsp_valid === 1'b1)
        rd = rsp_data;
    end
    if (i == 40)
    begin
      n_fail++;
      final_report();
    end
  endtask
  task t_reset();
    op(DDPP_OP_WRITE, 1'b0, 16'h0abc);
    op(DDPP_OP_RESET, 1'b0, 16'h0000);
    chk(dac_a, `DDPP_CODE_MID);
    chk(dac_b, `DDPP_CODE_MID);
    op(DDPP_OP_READ, 1'b0, 16'h0000);
    chk(rd, `DDPP_CODE_MID);
    chk({15'h0000, cs_n}, 16'h0001);
    $display("test reset done");
  endtask
  task t_write_read();
    op(DDPP_OP_WRITE, 1'b0, 16'h1234);
    op(DDPP_OP_WRITE, 1'b1, 16'hfedc);
    chk(dac_a, `DDPP_CODE_MID);
    chk(dac_b, `DDPP_CODE_MID);
    op(DDPP_OP_READ, 1'b1, 16'h0000);
    chk(rd, 16'hfedc);
    op(DDPP_OP_READ, 1'b0, 16'h0000);
    chk(rd, 16'h1234);
    chk({15'h0000, db_oe}, 16'h0000);
    $display("test write read done");
  endtask
  task t_load();
    op(DDPP_OP_LOAD, 1'b0, 16'h0000);
    chk(dac_a, 16'h1234);
    chk(dac_b, 16'hfedc);
    op(DDPP_OP_LOAD, 1'b1, 16'hffff);
    op(DDPP_OP_READ, 1'b1, 16'h0000);
    chk(rd, 16'hfedc);
    chk(dac_a, 16'h1234);
    $display("test load done");
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    chk({15'h0000, req_ready}, 16'h0001);
    t_reset();
    t_write_read();
    t_load();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
